// File: shared/gpss_pkg.sv
// constants, types and helpers for the global power state sequencer
// Summary of operation
// - os-only platform: mode flag always reads one
// - dual-mode platform boots legacy, flag zero
// - legacy state entered only on dual-mode hardware
// - no os-visible interrupt while in legacy
// - enter value on command port starts switch
// - switch done: set flag, return to working
// - leave value: go legacy, clear flag
// - up to four sleep states, one active
// - enabled wake event returns sleep to working
// - type S5 plus enable runs shutdown sequence
// - processors halted while sleeping until wake
// - soft-off exit: flag per platform mode support
// - any power loss forces mechanical off
// - hardware events act with no software involvement
// - os-visible interrupt is level, never edge
// - interrupt events routed by mode flag
// - vendor transparent events always to firmware irq
// - power button raises event to its handler
// - sleep enable sits at control bit 13
// - sticky bit set by level, write-one clears
// - write-only bits act on one, read zero
// - reserved bits read zero, writes ignored
package gpss_pkg;
    // clock and sequencing times
    localparam int CLK_PERIOD_NS = 4;
    localparam int MODE_SWITCH_NS = 40;
    localparam int SHUTDOWN_NS = 80;
    localparam int MODE_SWITCH_CYC = (MODE_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHUTDOWN_CYC = (SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 5;
    // register byte offsets
    localparam logic [11:0] OFS_PM_CTRL = 12'h000;
    localparam logic [11:0] OFS_MODE_CMD = 12'h004;
    localparam logic [11:0] OFS_EVT_STS = 12'h008;
    localparam logic [11:0] OFS_EVT_EN = 12'h00C;
    localparam logic [11:0] OFS_STATE = 12'h010;
    // control register fields
    localparam int SLEEP_ENABLE_CONTROL_BIT = 13;
    localparam int SLP_TYP_LSB = 10;
    localparam int SLP_TYP_W = 3;
    localparam int FLAG_BIT = 0;
    localparam int STATE_SLP_LSB = 4;
    localparam int WAKE_EN_LSB = 8;
    // command values, arbitrary defaults
    localparam logic [7:0] ENTER_OS_MODE_VALUE = 8'hA0;
    localparam logic [7:0] LEAVE_OS_MODE_VALUE = 8'hA1;
    // sleep type codes
    localparam logic [2:0] SLP_S0 = 3'h0;
    localparam logic [2:0] SLP_S1 = 3'h1;
    localparam logic [2:0] SLP_S4 = 3'h4;
    localparam logic [2:0] SLP_S5 = 3'h5;
    // event vector layout
    localparam int NEV = 6;
    localparam int EV_PWRBTN = 0;
    localparam int EV_VENDOR = 5;
    localparam logic [NEV-1:0] EN_RST = 6'h00;
    localparam logic [7:0] CMD_RST = 8'h00;
    // global states, gray along boot, switch and sleep path
    typedef enum logic [2:0] {
        ST_G3 = 3'h0,
        ST_LEGACY = 3'h1,
        ST_MODESW = 3'h3,
        ST_G0 = 3'h2,
        ST_SLEEP = 3'h6,
        ST_SHUTDN = 3'h7,
        ST_SOFTOFF = 3'h5
    } gpss_state_t;
    // sleep codes S1..S4 are the only sleeping states
    function automatic logic gpss_is_sleep(input logic [2:0] t);
        return (t >= SLP_S1) && (t <= SLP_S4);
    endfunction
endpackage

// File: rtl/gpss_sticky.sv
// sticky event status bits with write-one-to-clear
`timescale 1ns/1ps
module gpss_sticky (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [gpss_pkg::NEV-1:0] set_i,
    input wire logic [gpss_pkg::NEV-1:0] clr_i,
    output logic [gpss_pkg::NEV-1:0] sts_o
);
    // level sets every cycle it is high; set beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts_o <= '0;
        end else begin
            sts_o <= (sts_o & ~clr_i) | set_i;
        end
    end

    chk_sticky_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (set_i != '0) |=> ((sts_o & $past(set_i)) == $past(set_i)))
        else $error("sticky bit missed its set level");
    chk_sticky_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (set_i == '0 && clr_i == '0) |=> (sts_o == $past(sts_o)))
        else $error("sticky bit changed with no set or clear");
endmodule

// File: rtl/gpss_irq_route.sv
// steering of pending events to firmware or os-visible interrupt
`timescale 1ns/1ps
module gpss_irq_route (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [gpss_pkg::NEV-1:0] pend_i,
    input wire logic flag_i,
    input wire logic legacy_i,
    output logic os_irq_o,
    output logic fw_irq_o
);
    logic vendor;
    logic shared_evt;

    // vendor events never leave the firmware path
    assign vendor = pend_i[gpss_pkg::EV_VENDOR];
    assign shared_evt = |(pend_i & ~(gpss_pkg::NEV'(1) << gpss_pkg::EV_VENDOR));

    // level outputs: held while any enabled status stays pending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            os_irq_o <= 1'b0;
            fw_irq_o <= 1'b0;
        end else begin
            os_irq_o <= shared_evt && flag_i && !legacy_i;
            fw_irq_o <= vendor || (shared_evt && !flag_i);
        end
    end

    chk_legacy_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        legacy_i |=> !os_irq_o)
        else $error("os interrupt raised in legacy state");
    chk_route_fw: assert property (@(posedge clk_i) disable iff (rst_i)
        (shared_evt && !flag_i) |=> (fw_irq_o && !os_irq_o))
        else $error("event not steered to firmware interrupt");
    chk_vendor_fw: assert property (@(posedge clk_i) disable iff (rst_i)
        vendor |=> fw_irq_o)
        else $error("vendor event missed firmware interrupt");
    chk_level_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        (shared_evt && flag_i && !legacy_i)[*2] |=> os_irq_o && $past(os_irq_o))
        else $error("os interrupt not held as a level");
endmodule

// File: rtl/gpss_top.sv
// global power state sequencer with apb register slave
`timescale 1ns/1ps
module gpss_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic dual_mode_i,
    input wire logic power_good_i,
    input wire logic pwr_btn_i,
    input wire logic lid_i,
    input wire logic dock_i,
    input wire logic thermal_i,
    input wire logic ring_i,
    input wire logic vendor_evt_i,
    output logic os_mode_flag_o,
    output logic [2:0] gstate_o,
    output logic [2:0] sleep_state_o,
    output logic cpu_run_o,
    output logic power_on_o,
    output logic os_irq_o,
    output logic fw_irq_o
);
    localparam int TMR_W_L = gpss_pkg::TMR_W;
    localparam logic [TMR_W_L-1:0] TMR_ONE = 5'h01;

    gpss_pkg::gpss_state_t state_r, state_nxt;
    logic dual_r;
    logic flag_r;
    logic [2:0] slp_typ_field_r;
    logic [2:0] sleep_type_r;
    logic [7:0] last_cmd_r;
    logic [gpss_pkg::NEV-1:0] int_en_r;
    logic [gpss_pkg::NEV-1:0] wake_en_r;
    logic [TMR_W_L-1:0] tmr_r;
    logic [gpss_pkg::NEV-1:0] evt_raw;
    logic [gpss_pkg::NEV-1:0] sts;
    logic [gpss_pkg::NEV-1:0] sts_clr;
    logic acc_cyc;
    logic wr_en;
    logic [31:0] rd_nxt;
    logic rd_err;
    logic wr_ctrl;
    logic wr_cmd;
    logic slp_go;
    logic [2:0] slp_code;
    logic enter_req;
    logic leave_req;
    logic wake_hit;
    logic tmr_done;
    logic boot_req;

    // raw event levels; power button feeds its own status bit
    assign evt_raw = {vendor_evt_i, ring_i, thermal_i, dock_i, lid_i, pwr_btn_i};

    // apb: access cycle answered one cycle later from flops
    assign acc_cyc = psel_i && penable_i && !pready_o;
    assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
    assign wr_ctrl = wr_en && (paddr_i == gpss_pkg::OFS_PM_CTRL);
    assign wr_cmd = wr_en && (paddr_i == gpss_pkg::OFS_MODE_CMD);
    // write-only enable acts only when a one is written
    assign slp_go = wr_ctrl && pwdata_i[gpss_pkg::SLEEP_ENABLE_CONTROL_BIT];
    assign slp_code = pwdata_i[gpss_pkg::SLP_TYP_LSB +: gpss_pkg::SLP_TYP_W];
    assign enter_req = wr_cmd && (pwdata_i[7:0] == gpss_pkg::ENTER_OS_MODE_VALUE);
    assign leave_req = wr_cmd && (pwdata_i[7:0] == gpss_pkg::LEAVE_OS_MODE_VALUE);
    // clearing a status bit needs a one written at its position
    assign sts_clr = (wr_en && (paddr_i == gpss_pkg::OFS_EVT_STS)) ?
        pwdata_i[gpss_pkg::NEV-1:0] : '0;
    // software is trusted to have enabled wakes before requesting sleep
    assign wake_hit = |(sts & wake_en_r);
    assign tmr_done = (tmr_r == TMR_ONE);
    // power button from soft off boots the platform with no software help
    assign boot_req = power_good_i && pwr_btn_i;

    gpss_sticky i_gpss_sticky (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(evt_raw),
        .clr_i(sts_clr),
        .sts_o(sts)
    );

    gpss_irq_route i_gpss_irq_route (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pend_i(sts & int_en_r),
        .flag_i(flag_r),
        .legacy_i(state_r == gpss_pkg::ST_LEGACY),
        .os_irq_o(os_irq_o),
        .fw_irq_o(fw_irq_o)
    );

    // read mux; reserved and write-only positions read zero
    always_comb begin
        rd_nxt = 32'h00000000;
        rd_err = 1'b0;
        unique case (paddr_i)
            gpss_pkg::OFS_PM_CTRL: begin
                rd_nxt[gpss_pkg::SLP_TYP_LSB +: gpss_pkg::SLP_TYP_W] = slp_typ_field_r;
                rd_nxt[gpss_pkg::FLAG_BIT] = flag_r;
            end
            gpss_pkg::OFS_MODE_CMD: rd_nxt[7:0] = last_cmd_r;
            gpss_pkg::OFS_EVT_STS: rd_nxt[gpss_pkg::NEV-1:0] = sts;
            gpss_pkg::OFS_EVT_EN: begin
                rd_nxt[gpss_pkg::NEV-1:0] = int_en_r;
                rd_nxt[gpss_pkg::WAKE_EN_LSB +: gpss_pkg::NEV] = wake_en_r;
            end
            gpss_pkg::OFS_STATE: begin
                rd_nxt[2:0] = state_r;
                rd_nxt[gpss_pkg::STATE_SLP_LSB +: 3] = sleep_type_r;
            end
            default: rd_err = 1'b1;
        endcase
    end

    // bus answer flops; unmapped addresses answer with an error
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= acc_cyc;
            if (acc_cyc) begin
                prdata_o <= pwrite_i ? 32'h00000000 : rd_nxt;
                pslverr_o <= rd_err;
            end else begin
                pslverr_o <= 1'b0;
            end
        end
    end

    // software-owned fields; only defined bits are stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slp_typ_field_r <= gpss_pkg::SLP_S0;
            last_cmd_r <= gpss_pkg::CMD_RST;
            int_en_r <= gpss_pkg::EN_RST;
            wake_en_r <= gpss_pkg::EN_RST;
        end else begin
            if (wr_ctrl) begin
                slp_typ_field_r <= slp_code;
            end
            if (wr_cmd) begin
                last_cmd_r <= pwdata_i[7:0];
            end
            if (wr_en && (paddr_i == gpss_pkg::OFS_EVT_EN)) begin
                int_en_r <= pwdata_i[gpss_pkg::NEV-1:0];
                wake_en_r <= pwdata_i[gpss_pkg::WAKE_EN_LSB +: gpss_pkg::NEV];
            end
        end
    end

    // next global state; power loss outranks everything
    always_comb begin
        state_nxt = state_r;
        if (!power_good_i) begin
            state_nxt = gpss_pkg::ST_G3;
        end else begin
            unique case (state_r)
                gpss_pkg::ST_G3, gpss_pkg::ST_SOFTOFF: begin
                    // a fresh boot: dual-mode parts start in legacy
                    if (state_r == gpss_pkg::ST_G3 || boot_req) begin
                        state_nxt = dual_r ? gpss_pkg::ST_LEGACY : gpss_pkg::ST_G0;
                    end
                end
                gpss_pkg::ST_LEGACY: begin
                    if (slp_go && slp_code == gpss_pkg::SLP_S5) begin
                        state_nxt = gpss_pkg::ST_SHUTDN;
                    end else if (slp_go && gpss_pkg::gpss_is_sleep(slp_code)) begin
                        state_nxt = gpss_pkg::ST_SLEEP;
                    end else if (enter_req) begin
                        state_nxt = gpss_pkg::ST_MODESW;
                    end
                end
                gpss_pkg::ST_MODESW: begin
                    if (tmr_done) begin
                        state_nxt = gpss_pkg::ST_G0;
                    end
                end
                gpss_pkg::ST_G0: begin
                    if (slp_go && slp_code == gpss_pkg::SLP_S5) begin
                        state_nxt = gpss_pkg::ST_SHUTDN;
                    end else if (slp_go && gpss_pkg::gpss_is_sleep(slp_code)) begin
                        state_nxt = gpss_pkg::ST_SLEEP;
                    end else if (leave_req && dual_r) begin
                        state_nxt = gpss_pkg::ST_LEGACY;
                    end
                end
                gpss_pkg::ST_SLEEP: begin
                    // wake returns to whichever working mode was left
                    if (wake_hit) begin
                        state_nxt = flag_r ? gpss_pkg::ST_G0 : gpss_pkg::ST_LEGACY;
                    end
                end
                gpss_pkg::ST_SHUTDN: begin
                    if (tmr_done) begin
                        state_nxt = gpss_pkg::ST_SOFTOFF;
                    end
                end
                default: state_nxt = gpss_pkg::ST_G3;
            endcase
        end
    end

    // state register and platform capability caught during reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= gpss_pkg::ST_G3;
            dual_r <= dual_mode_i;
        end else begin
            state_r <= state_nxt;
        end
    end

    // sequencing timer for mode switch and shutdown
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr_r <= '0;
        end else if (state_nxt == gpss_pkg::ST_MODESW && state_r != gpss_pkg::ST_MODESW) begin
            tmr_r <= TMR_W_L'(gpss_pkg::MODE_SWITCH_CYC);
        end else if (state_nxt == gpss_pkg::ST_SHUTDN && state_r != gpss_pkg::ST_SHUTDN) begin
            tmr_r <= TMR_W_L'(gpss_pkg::SHUTDOWN_CYC);
        end else if (tmr_r != '0) begin
            tmr_r <= tmr_r - TMR_ONE;
        end
    end

    // mode flag; an os-only platform pins it high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_r <= !dual_mode_i;
        end else if (!dual_r) begin
            flag_r <= 1'b1;
        end else if (state_r == gpss_pkg::ST_MODESW && tmr_done) begin
            flag_r <= 1'b1;
        end else if (state_nxt == gpss_pkg::ST_LEGACY) begin
            flag_r <= 1'b0;
        end
    end

    // latched sleep code: a single active sleeping state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_type_r <= gpss_pkg::SLP_S0;
        end else if (slp_go && (state_nxt == gpss_pkg::ST_SLEEP
                     || state_nxt == gpss_pkg::ST_SHUTDN) && state_r != state_nxt) begin
            // only a code that really starts a sequence is kept, no one-cycle junk
            sleep_type_r <= slp_code;
        end else if (state_nxt != gpss_pkg::ST_SLEEP && state_nxt != gpss_pkg::ST_SHUTDN
                     && state_nxt != gpss_pkg::ST_SOFTOFF) begin
            sleep_type_r <= gpss_pkg::SLP_S0;
        end
    end

    // platform outputs follow the next state so they line up with gstate_o
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_run_o <= 1'b0;
            power_on_o <= 1'b0;
        end else begin
            // processors stay frozen in every sleep and off state
            cpu_run_o <= (state_nxt == gpss_pkg::ST_G0) || (state_nxt == gpss_pkg::ST_LEGACY)
                || (state_nxt == gpss_pkg::ST_MODESW);
            power_on_o <= (state_nxt != gpss_pkg::ST_G3) && (state_nxt != gpss_pkg::ST_SOFTOFF);
        end
    end

    assign os_mode_flag_o = flag_r;
    assign gstate_o = state_r;
    assign sleep_state_o = sleep_type_r;

    chk_os_only_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        !dual_r |-> flag_r)
        else $error("os-only platform shows flag low");
    chk_dual_boot: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_G3 && power_good_i && dual_r)
        |=> (state_r == gpss_pkg::ST_LEGACY && !flag_r))
        else $error("dual-mode boot did not land in legacy");
    chk_legacy_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_LEGACY) |-> dual_r)
        else $error("legacy state on os-only hardware");
    chk_enter_mode: assert property (@(posedge clk_i) disable iff (rst_i || !power_good_i)
        (state_r == gpss_pkg::ST_LEGACY && enter_req && !slp_go)
        |=> (state_r == gpss_pkg::ST_MODESW && !flag_r)
        ##10 (state_r == gpss_pkg::ST_G0 && flag_r))
        else $error("mode switch did not complete with flag set");
    chk_leave_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_G0 && leave_req && dual_r && !slp_go && power_good_i)
        |=> (state_r == gpss_pkg::ST_LEGACY && !flag_r))
        else $error("leave command did not reach legacy");
    chk_sleep_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_G0 && slp_go && gpss_pkg::gpss_is_sleep(slp_code) && power_good_i)
        |=> (state_r == gpss_pkg::ST_SLEEP && sleep_state_o == $past(slp_code)))
        else $error("sleep entry lost its latched type");
    chk_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_SLEEP && wake_hit && power_good_i)
        |=> (state_r == gpss_pkg::ST_G0 || state_r == gpss_pkg::ST_LEGACY) ##1 cpu_run_o)
        else $error("enabled wake did not return to working");
    chk_soft_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_G0 && slp_go && slp_code == gpss_pkg::SLP_S5 && power_good_i)
        |=> (state_r == gpss_pkg::ST_SHUTDN) ##[19:21] (state_r == gpss_pkg::ST_SOFTOFF
        || !power_good_i || state_r == gpss_pkg::ST_G3))
        else $error("shutdown sequence did not reach soft off");
    chk_cpu_halt: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_SLEEP) |-> !cpu_run_o)
        else $error("processor running while asleep");
    chk_power_loss: assert property (@(posedge clk_i) disable iff (rst_i)
        !power_good_i |=> (state_r == gpss_pkg::ST_G3 && !power_on_o))
        else $error("power loss did not force mechanical off");
    chk_soft_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_SOFTOFF && boot_req)
        |=> (flag_r == !dual_r) && (state_r == (dual_r ? gpss_pkg::ST_LEGACY : gpss_pkg::ST_G0)))
        else $error("soft-off exit with wrong mode");

    // capability, event and sequencing checks
    chk_boot_os_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_G3 && power_good_i && !dual_r)
        |=> (state_r == gpss_pkg::ST_G0 && flag_r))
        else $error("os-only boot did not land in working");
    chk_btn_event: assert property (@(posedge clk_i) disable iff (rst_i)
        pwr_btn_i |=> sts[gpss_pkg::EV_PWRBTN])
        else $error("power button raised no event");
    chk_one_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_SLEEP) |-> gpss_pkg::gpss_is_sleep(sleep_type_r))
        else $error("sleeping with no valid sleep type");
    chk_type_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_G0) |-> (sleep_type_r == gpss_pkg::SLP_S0))
        else $error("stale sleep type while working");
    chk_hw_boot: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == gpss_pkg::ST_SOFTOFF && boot_req) |=> (cpu_run_o && power_on_o))
        else $error("power button did not boot from soft off");
    // reserved upper bits never carry data on any answer
    chk_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        pready_o |-> (prdata_o[31:14] == 18'h00000))
        else $error("reserved read bits not zero");
endmodule

// File: sim/gpss_event_src.sv
// behavioural platform event sources and power supply
`timescale 1ns/1ps
module gpss_event_src (
    input wire logic clk_i,
    input wire logic [gpss_pkg::NEV-1:0] req_i,
    input wire logic cut_i,
    output logic [gpss_pkg::NEV-1:0] evt_o,
    output logic power_good_o
);
    logic [gpss_pkg::NEV-1:0] d1_r = 6'h00;
    logic [gpss_pkg::NEV-1:0] d2_r = 6'h00;
    logic [gpss_pkg::NEV-1:0] d3_r = 6'h00;
    // stretch each request so the line is a level, not a blip
    always_ff @(posedge clk_i) begin
        d1_r <= req_i;
        d2_r <= d1_r;
        d3_r <= d2_r;
    end
    // lines held high four cycles, then back low
    assign evt_o = req_i | d1_r | d2_r | d3_r;
    // supply drops while cut, no warning given
    assign power_good_o = ~cut_i;
endmodule

// File: sim/tb_global_power_state_sequencer.sv
// self-checking bench for the global power state sequencer
`timescale 1ns/1ps
module tb_global_power_state_sequencer;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dual = 1'b1, cut = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, rd, prdata;
    logic [5:0] req = 6'h00, evt;
    logic pready, pslverr, pg, flag, cpu_run, pwr_on, os_irq, fw_irq, err;
    logic [2:0] gstate, slp;
    int n_fail = 0, samples_checked = 0;
    // 250 MHz clock
    always #2 clk_i = ~clk_i;
    gpss_top i_gpss_top (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .dual_mode_i(dual), .power_good_i(pg),
        .pwr_btn_i(evt[0]), .lid_i(evt[1]), .dock_i(evt[2]), .thermal_i(evt[3]),
        .ring_i(evt[4]), .vendor_evt_i(evt[5]), .os_mode_flag_o(flag), .gstate_o(gstate),
        .sleep_state_o(slp), .cpu_run_o(cpu_run), .power_on_o(pwr_on), .os_irq_o(os_irq),
        .fw_irq_o(fw_irq));
    gpss_event_src i_gpss_event_src (.clk_i(clk_i), .req_i(req), .cut_i(cut), .evt_o(evt),
        .power_good_o(pg));
    // verdict and end of run
    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; waits on pready as long as it takes, the watchdog ends a dead slave
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_st(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        while (gstate !== s && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        chk(gstate, s);
    endtask
    // ask the event source for a level event, then let it drop
    task automatic fire(input logic [5:0] m);
        @(posedge clk_i);
        req <= m;
        @(posedge clk_i);
        req <= 6'h00;
        repeat (6) @(posedge clk_i);
    endtask
    // main sequence: dual-mode boot through every global state, then os-only boot
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_st(gpss_pkg::ST_LEGACY, 4);
        chk(flag, 1'b0);
        apb(1'b0, 12'hFFC, 32'h00000000);
        chk(err, 1'b1);
        apb(1'b1, gpss_pkg::OFS_EVT_EN, 32'hFFFFFFFF);
        apb(1'b0, gpss_pkg::OFS_EVT_EN, 32'h00000000);
        chk(rd, 32'h00003F3F);
        fire(6'h02);
        chk(fw_irq, 1'b1);
        chk(os_irq, 1'b0);
        apb(1'b0, gpss_pkg::OFS_EVT_STS, 32'h00000000);
        chk(rd, 32'h00000002);
        apb(1'b1, gpss_pkg::OFS_EVT_STS, 32'h0000003F);
        apb(1'b0, gpss_pkg::OFS_EVT_STS, 32'h00000000);
        chk(rd, 32'h00000000);
        chk(fw_irq, 1'b0);
        apb(1'b1, gpss_pkg::OFS_MODE_CMD, {24'h000000, gpss_pkg::ENTER_OS_MODE_VALUE});
        wait_st(gpss_pkg::ST_MODESW, 3);
        wait_st(gpss_pkg::ST_G0, gpss_pkg::MODE_SWITCH_CYC + 2);
        chk(flag, 1'b1);
        fire(6'h02);
        chk(os_irq, 1'b1);
        chk(fw_irq, 1'b0);
        fire(6'h20);
        chk(fw_irq, 1'b1);
        apb(1'b1, gpss_pkg::OFS_EVT_STS, 32'h0000003F);
        // wakes enabled already, then type, then enable bit
        apb(1'b1, gpss_pkg::OFS_PM_CTRL, 32'h00000400);
        apb(1'b1, gpss_pkg::OFS_PM_CTRL, 32'h00002400);
        wait_st(gpss_pkg::ST_SLEEP, 4);
        chk(slp, 3'h1);
        chk(cpu_run, 1'b0);
        apb(1'b0, gpss_pkg::OFS_STATE, 32'h00000000);
        chk(rd, 32'h00000016);
        apb(1'b1, gpss_pkg::OFS_PM_CTRL, 32'h00001000);
        chk(slp, 3'h1);
        fire(6'h01);
        wait_st(gpss_pkg::ST_G0, 8);
        chk(cpu_run, 1'b1);
        apb(1'b0, gpss_pkg::OFS_EVT_STS, 32'h00000000);
        chk(rd, 32'h00000001);
        apb(1'b0, gpss_pkg::OFS_PM_CTRL, 32'h00000000);
        chk(rd, 32'h00001001);
        apb(1'b1, gpss_pkg::OFS_EVT_STS, 32'h0000003F);
        apb(1'b1, gpss_pkg::OFS_MODE_CMD, {24'h000000, gpss_pkg::LEAVE_OS_MODE_VALUE});
        wait_st(gpss_pkg::ST_LEGACY, 4);
        chk(flag, 1'b0);
        apb(1'b0, gpss_pkg::OFS_MODE_CMD, 32'h00000000);
        chk(rd, 32'h000000A1);
        apb(1'b1, gpss_pkg::OFS_PM_CTRL, 32'h00001400);
        apb(1'b1, gpss_pkg::OFS_PM_CTRL, 32'h00003400);
        wait_st(gpss_pkg::ST_SHUTDN, 4);
        wait_st(gpss_pkg::ST_SOFTOFF, gpss_pkg::SHUTDOWN_CYC + 2);
        chk(pwr_on, 1'b0);
        fire(6'h01);
        wait_st(gpss_pkg::ST_LEGACY, 8);
        chk(flag, 1'b0);
        @(posedge clk_i);
        cut <= 1'b1;
        wait_st(gpss_pkg::ST_G3, 4);
        chk(pwr_on, 1'b0);
        // os-only platform: second reset with the strap low
        cut <= 1'b0;
        rst_i <= 1'b1;
        dual <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_st(gpss_pkg::ST_G0, 4);
        apb(1'b0, gpss_pkg::OFS_PM_CTRL, 32'h00000000);
        chk(rd[0], 1'b1);
        report_and_stop();
    end
    // watchdog well past the few hundred cycles the sequence needs
    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end
endmodule
